/* File: hdl/pcd_pkg.sv */
// Package of constants for the PC Card DMA and Ide_mode_control block
package pcd_pkg;
    // Register offsets on the indexed register port
    localparam logic [7:0] OFS_TIMING = 8'h16;
    localparam logic [7:0] OFS_GLOBAL = 8'h1e;
    localparam logic [7:0] OFS_IDE = 8'h3e;
    localparam logic [7:0] OFS_DMA = 8'h3f;
    localparam logic [7:0] OFS_STATUS_CHANGE = 8'h04;
    // Reset values
    localparam logic [7:0] RST_GLOBAL = 8'h00;
    localparam logic [7:0] RST_IDE = 8'h00;
    localparam logic [7:0] RST_DMA = 8'h00;
    localparam logic [7:0] RST_TIMING = 8'h00;
    // Timing register fields
    localparam int TIM_SHORT_CMD = 7;
    localparam int TIM_TC_LONG = 6;
    localparam int TIM_CFG_RESET = 5;
    localparam int TIM_SPKR_EN = 4;
    localparam int TIM_SETUP_HI = 3;
    localparam int TIM_SETUP_LO = 2;
    localparam int TIM_VS1 = 1;
    localparam int TIM_VS2 = 0;
    localparam logic [7:0] TIM_WR_MASK = 8'h00dc;
    // Global register field
    localparam int GLB_CLEAR_MODE = 2;
    localparam logic [7:0] GLB_WR_MASK = 8'h0004;
    // IDE register fields
    localparam int IDE_ADDR_HI = 7;
    localparam int IDE_ADDR_LO = 3;
    localparam int IDE_RESET_INV = 2;
    localparam int IDE_IREQ_INV = 1;
    localparam int IDE_MODE_ATA = 0;
    // DMA register fields
    localparam int DMA_PIN_HI = 7;
    localparam int DMA_PIN_LO = 6;
    localparam int DMA_PULL_BVD = 4;
    localparam int DMA_PULL_INPACK = 3;
    localparam int DMA_CH_HI = 2;
    localparam int DMA_CH_LO = 0;
    localparam logic [7:0] DMA_WR_MASK = 8'h00df;
    localparam logic [1:0] PIN_NONE = 2'h0;
    localparam logic [1:0] PIN_INPACK = 2'h1;
    localparam logic [1:0] PIN_IOIS16 = 2'h2;
    localparam logic [1:0] PIN_SPKR = 2'h3;
    localparam logic [2:0] CH_RESERVED = 3'h4;
    // Timing in PCI clocks
    localparam int SHORT_CMD_CLKS = 6;
    localparam int ISA_CMD_CLKS = 15;
    localparam int SETUP_MAX_CLKS = 3;
    localparam int TC_EXTRA_CLKS = 1;
    typedef enum logic [2:0] {
        PCD_IDLE,
        PCD_SETUP,
        PCD_CMD,
        PCD_HOLD
    } pcd_state_t;
endpackage : pcd_pkg

/* File: hdl/pcd_event_reg.sv */
// Status change event register with two clear modes
`timescale 1ns/100ps
module pcd_event_reg #(
    parameter int WIDTH = 8
) (
    input wire logic clk, // Clock
    input wire logic reset, // Synchronous reset
    input wire logic [WIDTH-1:0] event_set, // Event pulses
    input wire logic read_strobe, // Register read
    input wire logic write_strobe, // Register write
    input wire logic [WIDTH-1:0] write_data, // Write data
    input wire logic clear_by_write, // Clear mode
    output logic [WIDTH-1:0] events // Sticky events
);
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            always_ff @(posedge clk) begin
                if (reset) begin
                    events[i] <= 1'b0;
                end else if (event_set[i]) begin
                    events[i] <= 1'b1;
                end else if (!clear_by_write && read_strobe) begin
                    events[i] <= 1'b0;
                end else if (clear_by_write && write_strobe &&
                        write_data[i]) begin
                    events[i] <= 1'b0;
                end
            end
        end
    endgenerate
endmodule : pcd_event_reg

/* File: hdl/pcd_ctrl.sv */
// Per-slot DMA, ATA and timing control for a 16-bit PC Card socket
`timescale 1ns/100ps
module pcd_ctrl (
    input wire logic clk, // 50 MHz clock
    input wire logic reset, // Synchronous reset
    input wire logic [7:0] reg_index, // Register index
    input wire logic reg_write, // Register write strobe
    input wire logic reg_read, // Register read strobe
    input wire logic [7:0] reg_wdata, // Register write data
    output logic [7:0] reg_rdata, // Register read data
    input wire logic [7:0] change_events, // Status change pulses
    input wire logic host_speaker_enable, // Host feature enable bit
    input wire logic sense_pullup_disable, // CD and VS pull-up off
    input wire logic card_vs1, // Voltage sense 1
    input wire logic card_vs2, // Voltage sense 2
    input wire logic card_inpack_n, // INPACK# pin
    input wire logic card_iois16_n, // IOIS16# pin
    input wire logic card_spkr_n, // SPKR# pin
    input wire logic card_ireq_n, // Card interrupt input
    input wire logic card_reset_in, // Socket reset request
    input wire logic [9:0] io_addr, // I/O cycle address
    input wire logic io_start, // Start I/O cycle pulse
    input wire logic io_is_write, // I/O cycle is a write
    input wire logic mem_start, // Start memory cycle pulse
    input wire logic dma_ack_grant, // System acknowledge
    input wire logic dma_terminal, // System terminal count
    input wire logic dma_is_read, // DMA read, memory to card
    input wire logic speaker_in, // Card speaker level
    output logic [7:0] system_dma_channel_request, // Channel requests
    output logic card_reg_n, // REG#, acknowledge during DMA
    output logic card_ior_n, // IOR#
    output logic card_iow_n, // IOW#
    output logic card_oe_n, // OE#
    output logic card_we_n, // WE#
    output logic card_ce1_n, // CE1#
    output logic card_ce2_n, // CE2#
    output logic [25:21] card_addr_hi, // Card A25 to A21
    output logic card_addr_hi_oe, // Drive A25 to A21
    output logic card_reset, // Card reset output
    output logic card_ireq, // Interrupt to host, active high unless IDE_IREQ_INV is set
    output logic speaker_output, // Speaker output
    output logic pullup_bvd_rdy, // BVD and RDY pull-up enable
    output logic pullup_inpack_wait, // INPACK and WAIT pull-ups
    output logic pullup_sense, // CD and VS pull-up enable
    output logic cycle_busy, // Card cycle in progress
    output logic [7:0] status_change // Sticky status events
);
    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [7:0] timing_ctrl;
    logic [7:0] clear_ctrl;
    logic [7:0] ide_ctrl;
    logic [7:0] dma_ctrl;
    logic clear_by_write;
    logic wr_status;
    logic rd_status;

    always_ff @(posedge clk) begin
        if (reset) begin
            timing_ctrl <= pcd_pkg::RST_TIMING;
            clear_ctrl <= pcd_pkg::RST_GLOBAL;
            ide_ctrl <= pcd_pkg::RST_IDE;
            dma_ctrl <= pcd_pkg::RST_DMA;
        end else if (reg_write) begin
            if (reg_index == pcd_pkg::OFS_TIMING) begin
                timing_ctrl <= reg_wdata & pcd_pkg::TIM_WR_MASK;
            end else if (reg_index == pcd_pkg::OFS_GLOBAL) begin
                clear_ctrl <= reg_wdata & pcd_pkg::GLB_WR_MASK;
            end else if (reg_index == pcd_pkg::OFS_IDE) begin
                ide_ctrl <= reg_wdata;
            end else if (reg_index == pcd_pkg::OFS_DMA) begin
                dma_ctrl <= reg_wdata & pcd_pkg::DMA_WR_MASK;
            end
        end
    end

    assign clear_by_write = clear_ctrl[pcd_pkg::GLB_CLEAR_MODE];
    assign wr_status = reg_write &&
        (reg_index == pcd_pkg::OFS_STATUS_CHANGE);
    assign rd_status = reg_read &&
        (reg_index == pcd_pkg::OFS_STATUS_CHANGE);

    pcd_event_reg #(
        .WIDTH(8)
    ) u_events (
        .clk(clk),
        .reset(reset),
        .event_set(change_events),
        .read_strobe(rd_status),
        .write_strobe(wr_status),
        .write_data(reg_wdata),
        .clear_by_write(clear_by_write),
        .events(status_change)
    );

    // Read data from flip-flops; unmapped indices read zero
    always_ff @(posedge clk) begin
        if (reset) begin
            reg_rdata <= 8'h00;
        end else if (reg_read) begin
            if (reg_index == pcd_pkg::OFS_TIMING) begin
                reg_rdata <= timing_ctrl;
                reg_rdata[pcd_pkg::TIM_CFG_RESET] <= 1'b1;
                reg_rdata[pcd_pkg::TIM_VS1] <= card_vs1;
                reg_rdata[pcd_pkg::TIM_VS2] <= card_vs2;
            end else if (reg_index == pcd_pkg::OFS_GLOBAL) begin
                reg_rdata <= clear_ctrl;
            end else if (reg_index == pcd_pkg::OFS_IDE) begin
                reg_rdata <= ide_ctrl;
            end else if (reg_index == pcd_pkg::OFS_DMA) begin
                reg_rdata <= dma_ctrl;
            end else if (reg_index == pcd_pkg::OFS_STATUS_CHANGE) begin
                reg_rdata <= status_change;
            end else begin
                reg_rdata <= 8'h00;
            end
        end
    end

    // ------------------------------------------------------------
    // Static control outputs
    // ------------------------------------------------------------
    logic ata_mode;
    assign ata_mode = ide_ctrl[pcd_pkg::IDE_MODE_ATA];

    always_ff @(posedge clk) begin
        if (reset) begin
            pullup_bvd_rdy <= 1'b0;
            pullup_inpack_wait <= 1'b0;
            pullup_sense <= 1'b0;
            card_addr_hi <= 5'h00;
            card_addr_hi_oe <= 1'b0;
            card_reset <= 1'b0;
            card_ireq <= 1'b0;
            speaker_output <= 1'b0;
        end else begin
            pullup_bvd_rdy <= dma_ctrl[pcd_pkg::DMA_PULL_BVD];
            pullup_inpack_wait <=
                dma_ctrl[pcd_pkg::DMA_PULL_INPACK];
            pullup_sense <= !sense_pullup_disable;
            card_addr_hi <= ide_ctrl[pcd_pkg::IDE_ADDR_HI:
                pcd_pkg::IDE_ADDR_LO];
            card_addr_hi_oe <= ata_mode;
            card_reset <= card_reset_in ^
                ide_ctrl[pcd_pkg::IDE_RESET_INV];
            card_ireq <= (!card_ireq_n) ^
                ide_ctrl[pcd_pkg::IDE_IREQ_INV];
            speaker_output <= speaker_in && host_speaker_enable &&
                timing_ctrl[pcd_pkg::TIM_SPKR_EN];
        end
    end

    // ------------------------------------------------------------
    // DMA request selection and routing
    // ------------------------------------------------------------
    logic [1:0] req_pin;
    logic [2:0] req_ch;
    logic card_req;
    assign req_pin = dma_ctrl[pcd_pkg::DMA_PIN_HI:pcd_pkg::DMA_PIN_LO];
    assign req_ch = dma_ctrl[pcd_pkg::DMA_CH_HI:pcd_pkg::DMA_CH_LO];

    always_comb begin
        case (req_pin)
            pcd_pkg::PIN_INPACK: card_req = !card_inpack_n;
            pcd_pkg::PIN_IOIS16: card_req = !card_iois16_n;
            pcd_pkg::PIN_SPKR: card_req = !card_spkr_n;
            default: card_req = 1'b0;
        endcase
    end

    genvar c;
    generate
        for (c = 0; c < 8; c++) begin : g_chan
            always_ff @(posedge clk) begin
                if (reset) begin
                    system_dma_channel_request[c] <= 1'b0;
                end else begin
                    system_dma_channel_request[c] <= card_req &&
                        (req_ch == 3'(c)) &&
                        (req_ch != pcd_pkg::CH_RESERVED);
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // Card cycle sequencer
    // ------------------------------------------------------------
    pcd_pkg::pcd_state_t state;
    logic [4:0] count;
    logic dma_cyc;
    logic cyc_write;
    logic cyc_mem;
    logic cyc_tc;
    logic cyc_a9;
    logic dma_start;
    logic [4:0] setup_clks;
    logic [4:0] cmd_clks;

    assign dma_start = dma_ack_grant && (req_pin != pcd_pkg::PIN_NONE);
    assign setup_clks = 5'(pcd_pkg::SETUP_MAX_CLKS) - 5'(timing_ctrl[
        pcd_pkg::TIM_SETUP_HI:pcd_pkg::TIM_SETUP_LO]);
    assign cmd_clks = timing_ctrl[pcd_pkg::TIM_SHORT_CMD] ?
        5'(pcd_pkg::SHORT_CMD_CLKS) :
        5'(pcd_pkg::ISA_CMD_CLKS);
    assign cycle_busy = (state != pcd_pkg::PCD_IDLE);

    always_ff @(posedge clk) begin
        if (reset) begin
            state <= pcd_pkg::PCD_IDLE;
            count <= 5'h00;
            dma_cyc <= 1'b0;
            cyc_write <= 1'b0;
            cyc_mem <= 1'b0;
            cyc_tc <= 1'b0;
            cyc_a9 <= 1'b0;
        end else begin
            case (state)
                pcd_pkg::PCD_IDLE: begin
                    if (dma_start) begin
                        // Card to memory on DMA write
                        dma_cyc <= 1'b1;
                        cyc_write <= dma_is_read;
                        cyc_mem <= 1'b0;
                        cyc_tc <= dma_terminal;
                        state <= pcd_pkg::PCD_CMD;
                        count <= cmd_clks;
                    end else if (io_start) begin
                        dma_cyc <= 1'b0;
                        cyc_write <= io_is_write;
                        cyc_mem <= 1'b0;
                        cyc_tc <= 1'b0;
                        cyc_a9 <= io_addr[9];
                        state <= pcd_pkg::PCD_CMD;
                        count <= cmd_clks;
                    end else if (mem_start) begin
                        dma_cyc <= 1'b0;
                        cyc_write <= io_is_write;
                        cyc_mem <= 1'b1;
                        cyc_tc <= 1'b0;
                        cyc_a9 <= io_addr[9];
                        if (setup_clks == 5'h00) begin
                            state <= pcd_pkg::PCD_CMD;
                            count <= cmd_clks;
                        end else begin
                            state <= pcd_pkg::PCD_SETUP;
                            count <= setup_clks;
                        end
                    end
                end
                pcd_pkg::PCD_SETUP: begin
                    if (count == 5'h01) begin
                        state <= pcd_pkg::PCD_CMD;
                        count <= cmd_clks;
                    end else begin
                        count <= count - 5'h01;
                    end
                end
                pcd_pkg::PCD_CMD: begin
                    if (count == 5'h01) begin
                        if (cyc_tc &&
                                timing_ctrl[pcd_pkg::TIM_TC_LONG]) begin
                            state <= pcd_pkg::PCD_HOLD;
                            count <= 5'(pcd_pkg::TC_EXTRA_CLKS);
                        end else begin
                            state <= pcd_pkg::PCD_IDLE;
                            dma_cyc <= 1'b0;
                        end
                    end else begin
                        count <= count - 5'h01;
                    end
                end
                pcd_pkg::PCD_HOLD: begin
                    state <= pcd_pkg::PCD_IDLE;
                    dma_cyc <= 1'b0;
                end
                default: state <= pcd_pkg::PCD_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Card strobes
    // ------------------------------------------------------------
    logic in_cmd;
    logic tc_on;
    logic sel_active;
    assign in_cmd = (state == pcd_pkg::PCD_CMD);
    // Short TC drops one clock before the command ends
    assign tc_on = cyc_tc && ((in_cmd && (count != 5'h01 ||
        timing_ctrl[pcd_pkg::TIM_TC_LONG])) ||
        (state == pcd_pkg::PCD_HOLD));
    assign sel_active = cycle_busy && !dma_cyc;

    always_comb begin
        // REG# low only in I/O cycles, high (DACK) through DMA
        card_reg_n = !(cycle_busy && !dma_cyc && !cyc_mem);
        card_ior_n = !(in_cmd && !cyc_mem && !cyc_write);
        card_iow_n = !(in_cmd && !cyc_mem && cyc_write);
        card_oe_n = 1'b1;
        card_we_n = 1'b1;
        if (cyc_mem) begin
            card_oe_n = !(in_cmd && !cyc_write);
            card_we_n = !(in_cmd && cyc_write);
        end else if (dma_cyc && tc_on) begin
            card_we_n = !cyc_write;
            card_oe_n = cyc_write;
        end
        if (ata_mode) begin
            card_ce1_n = !(sel_active && !cyc_a9);
            card_ce2_n = !(sel_active && cyc_a9);
        end else begin
            card_ce1_n = !cycle_busy;
            card_ce2_n = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_reg_dma_high: assert property (@(posedge clk) disable iff (reset)
        (state == pcd_pkg::PCD_IDLE && dma_start) |=>
        card_reg_n [*5])
        else $error("REG# not high during DMA cycle");
    a_tc_read_we: assert property (@(posedge clk) disable iff (reset)
        (tc_on && dma_cyc && cyc_write && in_cmd) |->
        (!card_we_n && !card_iow_n))
        else $error("TC on DMA read lacks WE#");
    a_no_dma_req: assert property (@(posedge clk) disable iff (reset)
        (req_pin == pcd_pkg::PIN_NONE) |=>
        (system_dma_channel_request == 8'h00))
        else $error("Request raised with DMA disabled");
    a_short_cmd_len: assert property (@(posedge clk) disable iff (reset)
        ($rose(in_cmd) && timing_ctrl[pcd_pkg::TIM_SHORT_CMD]) |->
        in_cmd [*6] ##1 !in_cmd)
        else $error("Short command not six clocks");
    a_cfg_reset_one: assert property (@(posedge clk) disable iff (reset)
        (reg_read && reg_index == pcd_pkg::OFS_TIMING) |=>
        reg_rdata[pcd_pkg::TIM_CFG_RESET])
        else $error("Config reset bit read zero");
    a_ata_cs_split: assert property (@(posedge clk) disable iff (reset)
        (ata_mode && sel_active) |-> (card_ce1_n != card_ce2_n))
        else $error("ATA chip selects not exclusive");
    a_setup_none: assert property (@(posedge clk) disable iff (reset)
        (state == pcd_pkg::PCD_IDLE && !dma_start && !io_start &&
        mem_start && setup_clks == 5'h00) |=> in_cmd)
        else $error("Setup not skipped");
    a_speaker_gate: assert property (@(posedge clk) disable iff (reset)
        !host_speaker_enable |=> !speaker_output)
        else $error("Speaker driven without host enable");
endmodule : pcd_ctrl

/* File: dv/pcd_card_model.sv */
// Behavioural PC Card raising DMA requests on a chosen pin
`timescale 1ns/100ps
module pcd_card_model (
    input wire logic clk, // Clock
    input wire logic want, // Start asking for service
    input wire logic [1:0] pin, // Request pin select
    input wire logic card_reg_n, // Acknowledge on REG#
    input wire logic card_ior_n, // IOR#
    input wire logic card_iow_n, // IOW#
    output logic card_inpack_n, // INPACK#
    output logic card_iois16_n, // IOIS16#
    output logic card_spkr_n // SPKR#
);
    logic asking = 1'b0;
    // Request held until acknowledge with a command
    always @(posedge clk) begin
        if (card_reg_n && !(card_ior_n && card_iow_n))
            asking <= 1'b0;
        else if (want)
            asking <= 1'b1;
    end
    assign card_inpack_n = !(asking && pin <= 2'h1);
    assign card_iois16_n = !(asking && pin == 2'h2);
    assign card_spkr_n = !(asking && pin == 2'h3);
endmodule : pcd_card_model

/* File: dv/pcd_ctrl_tb.sv */
// Self-checking bench for the PC Card DMA and Ide_mode_control block
`timescale 1ns/100ps
module pcd_ctrl_tb;
    logic clk = 0, reset = 1, reg_write = 0, reg_read = 0, want = 0;
    logic [7:0] reg_index = 0, reg_wdata = 0, change_events = 0, d;
    logic host_speaker_enable = 0, sense_pullup_disable = 0;
    logic card_vs1 = 1, card_vs2 = 0, card_ireq_n = 1, card_reset_in = 0;
    logic io_start = 0, io_is_write = 0, mem_start = 0, dma_ack_grant = 0;
    logic dma_terminal = 0, dma_is_read = 0, speaker_in = 0;
    logic [9:0] io_addr = 0;
    logic [1:0] pin = 0;
    logic card_inpack_n, card_iois16_n, card_spkr_n, card_reg_n, card_ior_n;
    logic card_iow_n, card_oe_n, card_we_n, card_ce1_n, card_ce2_n;
    logic card_addr_hi_oe, card_reset, card_ireq, speaker_output;
    logic pullup_bvd_rdy, pullup_inpack_wait, pullup_sense, cycle_busy;
    logic [7:0] reg_rdata, system_dma_channel_request, status_change;
    logic [25:21] card_addr_hi;
    int n_mismatch = 0, cmp_count = 0, n, tc, bad;
    int m_tim = 0, m_glb = 0, m_ide = 0, m_dma = 0, m_ev = 0;
    int idx_q[$] = '{'h16, 'h1e, 'h3e, 'h3f, 'h04, 'h55};

    pcd_ctrl DUT (
        .clk, .reset, .reg_index, .reg_write, .reg_read, .reg_wdata,
        .reg_rdata, .change_events, .host_speaker_enable,
        .sense_pullup_disable, .card_vs1, .card_vs2, .card_inpack_n,
        .card_iois16_n, .card_spkr_n, .card_ireq_n, .card_reset_in,
        .io_addr, .io_start, .io_is_write, .mem_start, .dma_ack_grant,
        .dma_terminal, .dma_is_read, .speaker_in,
        .system_dma_channel_request, .card_reg_n, .card_ior_n,
        .card_iow_n, .card_oe_n, .card_we_n, .card_ce1_n, .card_ce2_n,
        .card_addr_hi, .card_addr_hi_oe, .card_reset, .card_ireq,
        .speaker_output, .pullup_bvd_rdy, .pullup_inpack_wait,
        .pullup_sense, .cycle_busy, .status_change);
    pcd_card_model u_card (.clk, .want, .pin, .card_reg_n, .card_ior_n,
        .card_iow_n, .card_inpack_n, .card_iois16_n, .card_spkr_n);

    initial begin
        forever #10 clk = ~clk;
    end

    // ----------------------------------------
    // Reference model and shared tasks
    // ----------------------------------------
    function automatic int exp_rd(int idx);
        case (idx)
            'h16: return m_tim | 'h20 | (card_vs1 << 1) | card_vs2;
            'h1e: return m_glb;
            'h3e: return m_ide;
            'h3f: return m_dma;
            'h04: return m_ev;
            default: return 0;
        endcase
    endfunction : exp_rd
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("FAIL t=%0t got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic conclude();
        $display("Mismatches %0d, comparisons %0d", n_mismatch, cmp_count);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : conclude
    task automatic tick(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask : tick
    task automatic wr(input logic [7:0] idx, input logic [7:0] v);
        tick(1);
        reg_index = idx;
        reg_wdata = v;
        reg_write = 1;
        tick(1);
        reg_write = 0;
        case (idx)
            'h16: m_tim = v & pcd_pkg::TIM_WR_MASK;
            'h1e: m_glb = v & pcd_pkg::GLB_WR_MASK;
            'h3e: m_ide = v;
            'h3f: m_dma = v & pcd_pkg::DMA_WR_MASK;
            'h04: if (m_glb[2]) m_ev &= ~int'(v);
            default: ;
        endcase
    endtask : wr
    task automatic rd(input logic [7:0] idx);
        tick(1);
        reg_index = idx;
        reg_read = 1;
        tick(1);
        reg_read = 0;
        check(reg_rdata, 8'(exp_rd(idx)));
        if (idx == 8'h04 && !m_glb[2]) m_ev = 0;
    endtask : rd
    task automatic wait_idle();
        for (n = 0; cycle_busy !== 1'b0; n++) begin
            tick(1);
            if (n > 40) begin
                n_mismatch++;
                conclude();
            end
        end
    endtask : wait_idle

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        void'($urandom(32'hbadc));
        tick(5);
        reset = 0;
        foreach (idx_q[i]) rd(8'(idx_q[i]));
        foreach (idx_q[i]) wr(8'(idx_q[i]), 8'hff);
        foreach (idx_q[i]) rd(8'(idx_q[i]));
        // I/O cycles in ATA mode come before the DMA tests
        for (int i = 0; i < 4; i++) begin
            card_reset_in = i[0];
            card_ireq_n = i[1];
            d = 8'($urandom);
            wr(8'h3e, {d[7:3], 2'(i), 1'b1});
            tick(1);
            check(card_addr_hi, d[7:3]);
            check(card_addr_hi_oe, 1);
            check(card_reset, i[0] ^ i[1]);
            check(card_ireq, !i[1] ^ i[0]);
            io_addr = i[0] ? 10'h3f6 + 10'(d[0]) : 10'h1f0 + 10'(d[2:0]);
            io_is_write = i[1];
            io_start = 1;
            tick(1);
            io_start = 0;
            check({card_ce2_n, card_ce1_n}, i[0] ? 2'b01 : 2'b10);
            check(card_reg_n, 0);
            wait_idle();
        end
        for (int f = 0; f < 4; f++) begin
            wr(8'h16, {4'h0, 2'(f), 2'h0});
            mem_start = 1;
            tick(1);
            mem_start = 0;
            for (n = 0; card_oe_n && card_we_n && n < 9; n++) tick(1);
            check(8'(n), 8'(3 - f));
            wait_idle();
        end
        // DMA through every channel, pin, direction and TC mode
        for (int i = 0; i < 8; i++) begin
            pin = 2'(i % 3 + 1);
            wr(8'h16, {i[0], i[1], 6'h00});
            wr(8'h3f, {pin, 3'h0, 3'(i)});
            want = 1;
            tick(1);
            want = 0;
            tick(1);
            check(system_dma_channel_request, i == 4 ? 0 : 1 << i);
            dma_is_read = i[2];
            dma_terminal = (i != 3);
            dma_ack_grant = 1;
            tick(1);
            dma_ack_grant = 0;
            {n, tc, bad} = 0;
            repeat (20) begin
                n += !(i[2] ? card_iow_n : card_ior_n);
                tc += !(i[2] ? card_we_n : card_oe_n);
                bad += !(i[2] ? card_ior_n : card_iow_n);
                bad += cycle_busy && !card_reg_n;
                tick(1);
            end
            check(8'(n), i[0] ? 6 : 15);
            check(8'(tc), i == 3 ? 0 : (i[1] ? n + 1 : n - 1));
            check(8'(bad), 0);
            check(system_dma_channel_request, 0);
        end
        wr(8'h3f, 8'h07);
        pin = 0;
        want = 1;
        tick(1);
        want = 0;
        dma_ack_grant = 1;
        tick(1);
        dma_ack_grant = 0;
        check(system_dma_channel_request, 0);
        check(cycle_busy, 0);
        for (int m = 0; m < 2; m++) begin
            wr(8'h1e, 8'(m << 2));
            d = 8'($urandom);
            change_events = d;
            tick(1);
            change_events = 0;
            m_ev |= d;
            tick(1);
            check(status_change, 8'(m_ev));
            rd(8'h04);
            rd(8'h04);
            wr(8'h04, d & 8'h0f);
            rd(8'h04);
        end
        for (int k = 0; k < 4; k++) begin
            {card_vs1, card_vs2} = 2'(k);
            host_speaker_enable = k[0];
            sense_pullup_disable = k[1];
            speaker_in = 1;
            wr(8'h16, {3'h0, k[1], 4'h0});
            wr(8'h3f, {3'h0, k[0], k[1], 3'h0});
            tick(1);
            check(speaker_output, k == 3);
            check(pullup_bvd_rdy, k[0]);
            check(pullup_inpack_wait, k[1]);
            check(pullup_sense, !k[1]);
            rd(8'h16);
        end
        conclude();
    end
endmodule : pcd_ctrl_tb
